// ---- inc/adlf_pkg.sv ----
// adlf_pkg: constants, register map and carriers for the alarm delay and loop-fault block
package adlf_pkg;
	localparam int          ADLF_CLK_HZ       = 100000000;
	localparam int          ADLF_TICK_S       = 1;
	localparam int          ADLF_TICK_CYC     = ADLF_CLK_HZ * ADLF_TICK_S;
	localparam int          ADLF_NCH          = 4;
	localparam logic [9:0]  ADLF_DLY_MAX      = 10'h3e7;
	localparam logic [13:0] ADLF_LF_TIME_MAX  = 14'h270f;
	localparam logic [3:0]  ADLF_TYPE_NONE    = 4'h0;
	localparam logic [3:0]  ADLF_TYPE_LOOP    = 4'hc;
	localparam logic [3:0]  ADLF_TYPE_RATE    = 4'hd;
	// level and band in tenths (temperature) or hundredths (analog)
	localparam logic [15:0] ADLF_LVL_TEMP_RST = 16'h0050;
	localparam logic [15:0] ADLF_LVL_ANA_RST  = 16'h03e8;
	localparam logic [15:0] ADLF_BND_TEMP_RST = 16'h001e;
	localparam logic [15:0] ADLF_BND_ANA_RST  = 16'h0014;
	localparam logic [15:0] ADLF_LVL_TEMP_MIN = 16'h0001;
	localparam logic [15:0] ADLF_LVL_TEMP_MAX = 16'h270f;
	localparam logic [15:0] ADLF_LVL_ANA_MAX  = 16'h270f;
	// register byte offsets
	localparam logic [7:0]  ADLF_OFS_CTRL     = 8'h00;
	localparam logic [7:0]  ADLF_OFS_TYPE     = 8'h04;
	localparam logic [7:0]  ADLF_OFS_LATCH    = 8'h08;
	localparam logic [7:0]  ADLF_OFS_LFTIME   = 8'h0c;
	localparam logic [7:0]  ADLF_OFS_LFLVL    = 8'h10;
	localparam logic [7:0]  ADLF_OFS_LFBND    = 8'h14;
	localparam logic [7:0]  ADLF_OFS_STATUS   = 8'h18;
	localparam logic [7:0]  ADLF_OFS_ONDLY    = 8'h20;
	localparam logic [7:0]  ADLF_OFS_OFFDLY   = 8'h30;
	// control register fields and bus response codes
	localparam int          ADLF_CTRL_ANALOG  = 0;
	localparam int          ADLF_CTRL_REINIT  = 1;
	localparam int          ADLF_CTRL_ASSIGN  = 4;
	localparam logic [1:0]  ADLF_RESP_OKAY    = 2'b00;
	localparam logic [1:0]  ADLF_RESP_SLVERR  = 2'b10;

	typedef struct packed {
		logic        ramp;
		logic        tuning;
		logic        manual;
		logic        stopped;
		logic        heat_cool;
		logic        at_done;
		logic [13:0] at_time;
	} adlf_loop_state_type;

	typedef struct packed {
		logic [15:0] set_point;
		logic [15:0] process_value;
	} adlf_process_type;
endpackage : adlf_pkg

// ---- logic/adlf_top.sv ----
// adlf_top: alarm on/off delay filters and loop-fault monitor with an axi4-lite slave
//
// Implementation choices: the AXI4-Lite register port and the register addresses.
`timescale 1ns/10ps
module adlf_top
	import adlf_pkg::*;
#(
	parameter int TICK_CYC = ADLF_TICK_CYC
)(
	input  wire logic                 mclk_i,
	input  wire logic                 rst_i,
	input  wire logic [3:0]           raw_alarm_i,
	input  wire logic                 setting_level_i,
	input  wire logic                 adc_error_i,
	input  wire adlf_loop_state_type  loop_state_i,
	input  wire adlf_process_type     process_i,
	output logic [3:0]                alarm_out_o,
	output logic                      aux_output_indicator_one_o,
	output logic                      aux_output_indicator_two_o,
	output logic                      aux_output_indicator_three_o,
	output logic                      aux_output_indicator_four_o,
	output logic                      loop_fault_alarm_o,
	input  wire logic [7:0]           s_axi_awaddr,
	input  wire logic                 s_axi_awvalid,
	output logic                      s_axi_awready,
	input  wire logic [31:0]          s_axi_wdata,
	input  wire logic [3:0]           s_axi_wstrb,
	input  wire logic                 s_axi_wvalid,
	output logic                      s_axi_wready,
	output logic [1:0]                s_axi_bresp,
	output logic                      s_axi_bvalid,
	input  wire logic                 s_axi_bready,
	input  wire logic [7:0]           s_axi_araddr,
	input  wire logic                 s_axi_arvalid,
	output logic                      s_axi_arready,
	output logic [31:0]               s_axi_rdata,
	output logic [1:0]                s_axi_rresp,
	output logic                      s_axi_rvalid,
	input  wire logic                 s_axi_rready
);
	logic [9:0]  on_dly_q   [ADLF_NCH];
	logic [9:0]  off_dly_q  [ADLF_NCH];
	logic [3:0]  type_q     [ADLF_NCH];
	logic [3:0]  assign_q;
	logic        analog_q;
	logic        reinit_q;
	logic        latch_q;
	logic [13:0] lf_time_q;
	logic [15:0] lf_lvl_q;
	logic [15:0] lf_bnd_q;
	logic [3:0]  raw_s1_q;
	logic [3:0]  raw_s2_q;
	logic [2:0]  lvl_s1_q;
	logic [2:0]  lvl_s2_q;
	logic        set_lvl_s;
	logic        adc_err_s;
	logic        lvl_prev_q;
	logic        restart;
	logic        force_off;
	logic [26:0] tick_cnt_q;
	logic        tick;
	logic [3:0]  alarm_q;
	logic        lf_q;
	logic        lf_hold_q;
	logic [13:0] lf_cnt_q;
	logic signed [16:0] dev_ref_q;
	logic signed [16:0] dev;
	logic        lf_run;
	logic        outside;
	logic        aw_got_q;
	logic        w_got_q;
	logic [7:0]  aw_addr_q;
	logic [31:0] w_data_q;
	logic [3:0]  w_strb_q;
	logic        wr_fire;
	logic [31:0] rd_word;
	logic        rd_ok;

	// second stage only feeds logic; first stage feeds nothing else
	always_ff @(posedge mclk_i)
	begin
		raw_s1_q <= raw_alarm_i;
		raw_s2_q <= raw_s1_q;
		lvl_s1_q <= {setting_level_i, adc_error_i, 1'b0};
		lvl_s2_q <= lvl_s1_q;
	end
	assign set_lvl_s = lvl_s2_q[2];
	assign adc_err_s = lvl_s2_q[1];
	assign force_off = set_lvl_s | adc_err_s;

	always_ff @(posedge mclk_i)
	begin
		if (rst_i)
			lvl_prev_q <= 1'b1;
		else
			lvl_prev_q <= set_lvl_s;
	end
	// leaving setting level, a software reinit or reset all restart the timers
	assign restart = (lvl_prev_q & ~set_lvl_s) | reinit_q;

	// one-second tick
	always_ff @(posedge mclk_i)
	begin
		if (rst_i || restart || tick)
			tick_cnt_q <= '0;
		else
			tick_cnt_q <= tick_cnt_q + 27'h1;
	end
	assign tick = (tick_cnt_q == 27'(TICK_CYC - 1));

	// per-channel delay filters
	genvar g;
	generate
		for (g = 0; g < ADLF_NCH; g++)
		begin : g_ch
			logic [9:0] cnt_q;
			logic       use_dly;
			logic [9:0] dly;
			logic       want;
			assign want = raw_s2_q[g];
			assign use_dly = assign_q[g] && (type_q[g] != ADLF_TYPE_NONE) && (type_q[g] != ADLF_TYPE_LOOP)
				&& (type_q[g] != ADLF_TYPE_RATE);
			assign dly = !use_dly ? 10'h0 : (alarm_q[g] ? off_dly_q[g] : on_dly_q[g]);
			always_ff @(posedge mclk_i)
			begin
				if (rst_i || force_off)
				begin
					alarm_q[g] <= 1'b0;
					cnt_q      <= '0;
				end
				else if (restart)
				begin
					alarm_q[g] <= 1'b0;
					cnt_q      <= '0;
				end
				else if (want == alarm_q[g])
					cnt_q <= '0;
				else if (dly == 10'h0)
				begin
					alarm_q[g] <= want;
					cnt_q      <= '0;
				end
				else if (tick)
				begin
					// strictly longer than the delay: change on the tick after it expires
					if (cnt_q >= dly)
					begin
						alarm_q[g] <= want;
						cnt_q      <= '0;
					end
					else
						cnt_q <= cnt_q + 10'h1;
				end
			end
		end
	endgenerate

	// loop-fault monitor
	assign dev     = 17'(signed'({1'b0, process_i.set_point})) - 17'(signed'({1'b0, process_i.process_value}));
	assign outside = dev > signed'({1'b0, lf_lvl_q});
	assign lf_run  = (lf_time_q != 14'h0) && (type_q[0] == ADLF_TYPE_LOOP) && assign_q[0]
		&& !loop_state_i.ramp && !loop_state_i.tuning && !loop_state_i.manual && !loop_state_i.stopped;

	always_ff @(posedge mclk_i)
	begin
		if (rst_i || restart || force_off || !lf_run || !outside)
		begin
			lf_q      <= 1'b0;
			lf_cnt_q  <= '0;
			dev_ref_q <= dev;
		end
		else if (dev_ref_q - dev >= signed'({1'b0, lf_bnd_q}))
		begin
			lf_q      <= 1'b0;
			lf_cnt_q  <= '0;
			dev_ref_q <= dev;
		end
		else if (tick)
		begin
			if (lf_cnt_q + 14'h1 >= lf_time_q)
			begin
				lf_q      <= 1'b1;
				lf_cnt_q  <= '0;
				dev_ref_q <= dev;
			end
			else
				lf_cnt_q <= lf_cnt_q + 14'h1;
		end
	end

	always_ff @(posedge mclk_i)
	begin
		if (rst_i || restart || force_off || !latch_q)
			lf_hold_q <= 1'b0;
		else if (lf_q)
			lf_hold_q <= 1'b1;
	end

	// outputs, one source for pins, indicators and status word
	always_ff @(posedge mclk_i)
	begin
		if (rst_i)
			alarm_out_o <= '0;
		else if (force_off)
			alarm_out_o <= '0;
		else
			alarm_out_o <= {alarm_q[3:1], (type_q[0] == ADLF_TYPE_LOOP) ? (lf_q | lf_hold_q) : alarm_q[0]};
	end
	assign aux_output_indicator_one_o   = alarm_out_o[0];
	assign aux_output_indicator_two_o   = alarm_out_o[1];
	assign aux_output_indicator_three_o = alarm_out_o[2];
	assign aux_output_indicator_four_o  = alarm_out_o[3];
	assign loop_fault_alarm_o           = alarm_out_o[0] & (type_q[0] == ADLF_TYPE_LOOP);

	// axi4-lite write side: address and data taken in either order
	assign s_axi_awready = !aw_got_q && !s_axi_bvalid;
	assign s_axi_wready  = !w_got_q && !s_axi_bvalid;
	assign wr_fire       = aw_got_q && w_got_q && !s_axi_bvalid;

	always_ff @(posedge mclk_i)
	begin
		if (rst_i)
		begin
			aw_got_q     <= 1'b0;
			w_got_q      <= 1'b0;
			aw_addr_q    <= '0;
			w_data_q     <= '0;
			w_strb_q     <= '0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp  <= ADLF_RESP_OKAY;
		end
		else
		begin
			if (s_axi_awvalid && s_axi_awready)
			begin
				aw_got_q  <= 1'b1;
				aw_addr_q <= s_axi_awaddr;
			end
			if (s_axi_wvalid && s_axi_wready)
			begin
				w_got_q  <= 1'b1;
				w_data_q <= s_axi_wdata;
				w_strb_q <= s_axi_wstrb;
			end
			if (wr_fire)
			begin
				aw_got_q     <= 1'b0;
				w_got_q      <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp  <= (aw_addr_q[7:2] <= ADLF_OFS_OFFDLY[7:2] + 6'h3) && (aw_addr_q[7:2] != 6'h7)
					&& (aw_addr_q[7:2] != 6'h6) ? ADLF_RESP_OKAY : ADLF_RESP_SLVERR;
			end
			else if (s_axi_bready)
				s_axi_bvalid <= 1'b0;
		end
	end

	// registers; full-word writes only take effect when all low lanes are enabled
	always_ff @(posedge mclk_i)
	begin
		if (rst_i)
		begin
			for (int i = 0; i < ADLF_NCH; i++)
			begin
				on_dly_q[i]  <= '0;
				off_dly_q[i] <= '0;
				type_q[i]    <= ADLF_TYPE_NONE;
			end
			assign_q  <= '0;
			analog_q  <= 1'b0;
			reinit_q  <= 1'b0;
			latch_q   <= 1'b0;
			lf_time_q <= '0;
			lf_lvl_q  <= ADLF_LVL_TEMP_RST;
			lf_bnd_q  <= ADLF_BND_TEMP_RST;
		end
		else
		begin
			reinit_q <= 1'b0;
			if (loop_state_i.at_done && !loop_state_i.heat_cool)
				lf_time_q <= (loop_state_i.at_time > ADLF_LF_TIME_MAX) ? ADLF_LF_TIME_MAX : loop_state_i.at_time;
			if (wr_fire && (w_strb_q[1:0] == 2'b11))
			begin
				case (aw_addr_q)
					ADLF_OFS_CTRL:
					begin
						if (w_data_q[ADLF_CTRL_ANALOG] != analog_q)
						begin
							lf_lvl_q <= w_data_q[ADLF_CTRL_ANALOG] ? ADLF_LVL_ANA_RST : ADLF_LVL_TEMP_RST;
							lf_bnd_q <= w_data_q[ADLF_CTRL_ANALOG] ? ADLF_BND_ANA_RST : ADLF_BND_TEMP_RST;
						end
						analog_q <= w_data_q[ADLF_CTRL_ANALOG];
						reinit_q <= w_data_q[ADLF_CTRL_REINIT];
						assign_q <= w_data_q[ADLF_CTRL_ASSIGN +: 4];
					end
					ADLF_OFS_TYPE:
						for (int i = 0; i < ADLF_NCH; i++)
							type_q[i] <= w_data_q[4 * i +: 4];
					ADLF_OFS_LATCH:
						latch_q <= w_data_q[0];
					ADLF_OFS_LFTIME:
						if (w_data_q[13:0] <= ADLF_LF_TIME_MAX)
							lf_time_q <= w_data_q[13:0];
					ADLF_OFS_LFLVL:
						if (w_data_q[15:0] >= ADLF_LVL_TEMP_MIN && w_data_q[15:0] <= ADLF_LVL_TEMP_MAX)
							lf_lvl_q <= w_data_q[15:0];
					ADLF_OFS_LFBND:
						if (w_data_q[15:0] <= ADLF_LVL_ANA_MAX)
							lf_bnd_q <= w_data_q[15:0];
					default:
						for (int i = 0; i < ADLF_NCH; i++)
						begin
							if (aw_addr_q == ADLF_OFS_ONDLY + 8'(4 * i) && w_data_q[9:0] <= ADLF_DLY_MAX)
								on_dly_q[i] <= w_data_q[9:0];
							if (aw_addr_q == ADLF_OFS_OFFDLY + 8'(4 * i) && w_data_q[9:0] <= ADLF_DLY_MAX)
								off_dly_q[i] <= w_data_q[9:0];
						end
				endcase
			end
		end
	end

	// read decode
	always_comb
	begin
		rd_word = '0;
		rd_ok   = 1'b1;
		case (s_axi_araddr)
			ADLF_OFS_CTRL:   rd_word = {24'h0, assign_q, 3'h0, analog_q};
			ADLF_OFS_TYPE:   rd_word = {16'h0, type_q[3], type_q[2], type_q[1], type_q[0]};
			ADLF_OFS_LATCH:  rd_word = {31'h0, latch_q};
			ADLF_OFS_LFTIME: rd_word = {18'h0, lf_time_q};
			ADLF_OFS_LFLVL:  rd_word = {16'h0, lf_lvl_q};
			ADLF_OFS_LFBND:  rd_word = {16'h0, lf_bnd_q};
			ADLF_OFS_STATUS: rd_word = {26'h0, lf_q, force_off, alarm_out_o};
			default:
			begin
				rd_ok = 1'b0;
				for (int i = 0; i < ADLF_NCH; i++)
				begin
					if (s_axi_araddr == ADLF_OFS_ONDLY + 8'(4 * i))
					begin
						rd_word = {22'h0, on_dly_q[i]};
						rd_ok   = 1'b1;
					end
					if (s_axi_araddr == ADLF_OFS_OFFDLY + 8'(4 * i))
					begin
						rd_word = {22'h0, off_dly_q[i]};
						rd_ok   = 1'b1;
					end
				end
			end
		endcase
	end

	assign s_axi_arready = !s_axi_rvalid;

	always_ff @(posedge mclk_i)
	begin
		if (rst_i)
		begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata  <= '0;
			s_axi_rresp  <= ADLF_RESP_OKAY;
		end
		else if (s_axi_arvalid && s_axi_arready)
		begin
			s_axi_rvalid <= 1'b1;
			s_axi_rdata  <= rd_word;
			s_axi_rresp  <= rd_ok ? ADLF_RESP_OKAY : ADLF_RESP_SLVERR;
		end
		else if (s_axi_rready)
			s_axi_rvalid <= 1'b0;
	end
endmodule : adlf_top

// ---- dv/adlf_top_assertions.sv ----
// adlf_top_assertions: port-level temporal checks for adlf_top
`timescale 1ns/10ps
module adlf_top_assertions
	import adlf_pkg::*;
(
	input wire logic                mclk_i,
	input wire logic                rst_i,
	input wire logic [3:0]          raw_alarm_i,
	input wire logic                setting_level_i,
	input wire logic                adc_error_i,
	input wire adlf_loop_state_type loop_state_i,
	input wire logic [3:0]          alarm_out_o,
	input wire logic                aux_output_indicator_one_o,
	input wire logic                aux_output_indicator_two_o,
	input wire logic                aux_output_indicator_three_o,
	input wire logic                aux_output_indicator_four_o,
	input wire logic                loop_fault_alarm_o
);
	default clocking cb @(posedge mclk_i);
	endclocking
	default disable iff (rst_i);
	// level and adc error cross a two-flop synchroniser and the output register; raw alarms add a filter stage, loop state no synchroniser
	sequence level_s; setting_level_i [*4]; endsequence
	sequence adc_s; adc_error_i [*4]; endsequence
	sequence ramp_s; loop_state_i.ramp [*3]; endsequence
	sequence idle_s; (loop_state_i.tuning || loop_state_i.manual || loop_state_i.stopped) [*3]; endsequence
	aux_one_a: assert property (aux_output_indicator_one_o == alarm_out_o[0]) else $error("aux one differs");
	aux_rest_a: assert property ({aux_output_indicator_four_o, aux_output_indicator_three_o,
		aux_output_indicator_two_o} == alarm_out_o[3:1]) else $error("aux indicators differ");
	level_off_a: assert property (level_s |-> alarm_out_o == 4'h0) else $error("setting level kept alarms");
	adc_off_a: assert property (adc_s |-> alarm_out_o == 4'h0) else $error("converter error kept alarms");
	rise_cause_a: assert property ($rose(alarm_out_o[1]) |-> $past(raw_alarm_i[1], 3) || $past(raw_alarm_i[1], 4))
		else $error("alarm rose without raw cause");
	fall_cause_a: assert property ($fell(alarm_out_o[1]) |-> !$past(raw_alarm_i[1], 3) || !$past(raw_alarm_i[1], 4)
		|| $past(setting_level_i, 3) || $past(adc_error_i, 3)) else $error("alarm fell without cause");
	lf_ch1_a: assert property (loop_fault_alarm_o |-> alarm_out_o[0]) else $error("loop fault not on channel one");
	ramp_hold_a: assert property (ramp_s |-> !loop_fault_alarm_o) else $error("loop fault during ramp");
	idle_hold_a: assert property (idle_s |-> !loop_fault_alarm_o) else $error("loop fault while suspended");
	rst_clear_a: assert property ($fell(rst_i) |-> (alarm_out_o == 4'h0) [*2]) else $error("alarm right after reset");
endmodule : adlf_top_assertions

bind adlf_top adlf_top_assertions i_chk (.mclk_i, .rst_i, .raw_alarm_i, .setting_level_i, .adc_error_i, .loop_state_i,
	.alarm_out_o, .aux_output_indicator_one_o, .aux_output_indicator_two_o, .aux_output_indicator_three_o,
	.aux_output_indicator_four_o, .loop_fault_alarm_o);

// ---- dv/adlf_loop_model.sv ----
// adlf_loop_model: far-side plant turning a commanded deviation into process values
`timescale 1ns/10ps
module adlf_loop_model
	import adlf_pkg::*;
(
	input  wire logic        mclk_i,
	input  wire logic [15:0] sp_i,
	input  wire logic [15:0] dev_i,
	output adlf_process_type process_o
);
	initial process_o = '0;
	// one sample of lag, as a real sensor would add
	always @(posedge mclk_i)
	begin
		process_o.set_point     <= sp_i;
		process_o.process_value <= sp_i - dev_i;
	end
endmodule : adlf_loop_model

// ---- dv/tb_alarm_delay_loop_fault.sv ----
// tb_alarm_delay_loop_fault: self-checking bench for alarm delays and loop fault
`timescale 1ns/10ps
module tb_alarm_delay_loop_fault
	import adlf_pkg::*;
;
	localparam int TK = 10;
	logic                mclk_i = 1'b0;
	logic                rst_i  = 1'b1;
	logic [3:0]          raw    = 4'h0;
	logic                lvl    = 1'b0;
	logic                adc    = 1'b0;
	adlf_loop_state_type ls     = '0;
	adlf_process_type    pr;
	logic [15:0]         dev    = 16'h0000;
	logic [3:0]          ao, aux;
	logic                lfa, awr, wrd, arr, bv, rv;
	logic [7:0]          awa    = 8'h00;
	logic [31:0]         wd     = 32'h0;
	logic [31:0]         rdat, rnd;
	logic [1:0]          br, rr;
	logic                awv    = 1'b0, wv = 1'b0, arv = 1'b0, bry = 1'b0, rry = 1'b0;
	logic [34:0]         q[$];
	int                  n_fail = 0, checks_done = 0, n;

	initial
	begin
		forever #5 mclk_i = ~mclk_i;
	end

	adlf_loop_model i_loop (.mclk_i(mclk_i), .sp_i(16'h03e8), .dev_i(dev), .process_o(pr));

	adlf_top #(.TICK_CYC(TK)) i_dut (.mclk_i(mclk_i), .rst_i(rst_i), .raw_alarm_i(raw), .setting_level_i(lvl),
		.adc_error_i(adc), .loop_state_i(ls), .process_i(pr), .alarm_out_o(ao),
		.aux_output_indicator_one_o(aux[0]), .aux_output_indicator_two_o(aux[1]),
		.aux_output_indicator_three_o(aux[2]), .aux_output_indicator_four_o(aux[3]), .loop_fault_alarm_o(lfa),
		.s_axi_awaddr(awa), .s_axi_awvalid(awv), .s_axi_awready(awr), .s_axi_wdata(wd), .s_axi_wstrb(4'hf),
		.s_axi_wvalid(wv), .s_axi_wready(wrd), .s_axi_bresp(br), .s_axi_bvalid(bv), .s_axi_bready(bry),
		.s_axi_araddr(awa), .s_axi_arvalid(arv), .s_axi_arready(arr), .s_axi_rdata(rdat), .s_axi_rresp(rr),
		.s_axi_rvalid(rv), .s_axi_rready(rry));

	task automatic summarize();
		$display("checks %0d mismatches %0d", checks_done, n_fail);
		if (n_fail == 0 && checks_done > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask : summarize

	task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] e);
		checks_done++;
		if (s !== e)
		begin
			n_fail++;
			$display("mismatch %s expected %h seen %h", nm, e, s);
		end
	endtask : chk

	task automatic tmo();
		n_fail++;
		$display("mismatch timeout expected answer seen none");
		summarize();
	endtask : tmo

	// one access at a time; each channel released only after its own handshake
	task automatic acc(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
		int k;
		logic pa, pw, pb;
		q.push_back({!w && er == ADLF_RESP_OKAY, er, w ? 32'h0 : d});
		pa = 1'b1;
		pw = w;
		pb = 1'b1;
		awa <= a;
		wd <= d;
		for (k = 0; k < 100 && pb; k++)
		begin
			awv <= pa && w;
			wv <= pw;
			arv <= pa && !w;
			bry <= pb && w;
			rry <= pb && !w;
			@(negedge mclk_i);
			pb = pb && !(w ? bv : rv);
			pa = pa && !(w ? awr : arr);
			pw = pw && !wrd;
			@(posedge mclk_i);
		end
		{awv, wv, arv, bry, rry} <= 5'h0;
		@(posedge mclk_i);
		if (pb)
			tmo();
	endtask : acc

	// one note popped per answer, so answers must come back in the order the accesses were queued
	always @(negedge mclk_i)
	begin : scoreboard
		logic [34:0] e;
		e = '0;
		if ((bv && bry) || (rv && rry))
		begin
			if (q.size() == 0)
				chk("queue", 32'h0, 32'h1);
			else
			begin
				e = q.pop_front();
				if (bv)
					chk("bresp", {30'h0, br}, {30'h0, e[33:32]});
				else
				begin
					chk("rresp", {30'h0, rr}, {30'h0, e[33:32]});
					if (e[34])
						chk("rdata", rdat, e[31:0]);
				end
			end
		end
	end

	task automatic wt(input int b, input logic v);
		for (n = 0; n < 500 && ao[b] !== v; n++)
			@(negedge mclk_i);
		@(posedge mclk_i);
		if (n >= 500)
			tmo();
	endtask : wt

	task automatic win(input string nm, input int lo, input int hi);
		chk(nm, 32'(n >= lo && n <= hi), 32'h1);
	endtask : win

	task automatic stay(input int b, input logic v);
		logic f;
		f = 1'b0;
		repeat (40)
		begin
			@(negedge mclk_i);
			f = f | (ao[b] !== v);
		end
		@(posedge mclk_i);
		chk("steady", 32'(f), 32'h0);
	endtask : stay

	task automatic tune(input logic [13:0] t);
		ls.at_time <= t;
		ls.at_done <= 1'b1;
		@(posedge mclk_i);
		ls.at_done <= 1'b0;
	endtask : tune

	initial
	begin
		void'($urandom(53));
		repeat (2) @(posedge mclk_i);
		rst_i <= 1'b0;
		@(posedge mclk_i);
		for (int i = 0; i < 8; i++)
			acc(0, ADLF_OFS_ONDLY + 8'(4 * i), 32'h0, ADLF_RESP_OKAY);
		acc(0, ADLF_OFS_LFTIME, 32'h0, ADLF_RESP_OKAY);
		acc(0, ADLF_OFS_LFLVL, 32'h50, ADLF_RESP_OKAY);
		acc(0, ADLF_OFS_LFBND, 32'h1e, ADLF_RESP_OKAY);
		acc(0, 8'h1c, 32'h0, ADLF_RESP_SLVERR);
		acc(1, 8'h1c, 32'h1, ADLF_RESP_SLVERR);
		acc(1, 8'h24, 32'h3e8, ADLF_RESP_OKAY);
		acc(0, 8'h24, 32'h0, ADLF_RESP_OKAY);
		rnd = $urandom % 1000;
		acc(1, 8'h3c, rnd, ADLF_RESP_OKAY);
		acc(0, 8'h3c, rnd, ADLF_RESP_OKAY);
		$display("test registers done");
		acc(1, ADLF_OFS_CTRL, 32'hf0, ADLF_RESP_OKAY);
		acc(1, ADLF_OFS_TYPE, 32'h2022, ADLF_RESP_OKAY);
		acc(1, 8'h24, 32'h2, ADLF_RESP_OKAY);
		acc(1, 8'h34, 32'h2, ADLF_RESP_OKAY);
		acc(1, 8'h28, 32'h5, ADLF_RESP_OKAY);
		raw <= 4'hc;
		wt(3, 1'b1);
		win("direct", 1, 5);
		wt(2, 1'b1);
		win("unqualified", 0, 5);
		chk("aux", {28'h0, aux}, 32'hc);
		acc(0, ADLF_OFS_STATUS, 32'hc, ADLF_RESP_OKAY);
		raw <= 4'h0;
		wt(2, 1'b0);
		$display("test direct done");
		raw[1] <= 1'b1;
		repeat (20) @(posedge mclk_i);
		raw[1] <= 1'b0;
		stay(1, 1'b0);
		raw[1] <= 1'b1;
		repeat (15) @(posedge mclk_i);
		raw[1] <= 1'b0;
		repeat (3) @(posedge mclk_i);
		raw[1] <= 1'b1;
		wt(1, 1'b1);
		win("on delay", 21, 36);
		raw[1] <= 1'b0;
		repeat (20) @(posedge mclk_i);
		raw[1] <= 1'b1;
		stay(1, 1'b1);
		raw[1] <= 1'b0;
		wt(1, 1'b0);
		win("off delay", 21, 36);
		$display("test delays done");
		raw[1] <= 1'b1;
		wt(1, 1'b1);
		lvl <= 1'b1;
		wt(1, 1'b0);
		win("level off", 1, 5);
		acc(0, ADLF_OFS_STATUS, 32'h10, ADLF_RESP_OKAY);
		lvl <= 1'b0;
		wt(1, 1'b1);
		win("restart on", 21, 40);
		adc <= 1'b1;
		wt(1, 1'b0);
		win("adc off", 1, 5);
		repeat (4) @(posedge mclk_i);
		adc <= 1'b0;
		raw <= 4'h0;
		repeat (50) @(posedge mclk_i);
		$display("test forced done");
		acc(1, ADLF_OFS_TYPE, 32'h202c, ADLF_RESP_OKAY);
		acc(1, ADLF_OFS_LFTIME, 32'h3, ADLF_RESP_OKAY);
		dev <= 16'd200;
		repeat (10) @(posedge mclk_i);
		dev <= 16'd190;
		wt(0, 1'b1);
		win("loop fault", 5, 30);
		chk("loop out", 32'(lfa), 32'h1);
		dev <= 16'd160;
		wt(0, 1'b0);
		win("loop clear", 1, 6);
		dev <= 16'd50;
		stay(0, 1'b0);
		dev <= 16'd200;
		ls.ramp <= 1'b1;
		stay(0, 1'b0);
		ls.ramp <= 1'b0;
		ls.tuning <= 1'b1;
		stay(0, 1'b0);
		acc(1, ADLF_OFS_LFTIME, 32'h0, ADLF_RESP_OKAY);
		ls.tuning <= 1'b0;
		stay(0, 1'b0);
		tune(14'd7);
		acc(0, ADLF_OFS_LFTIME, 32'h7, ADLF_RESP_OKAY);
		ls.heat_cool <= 1'b1;
		tune(14'd9);
		acc(0, ADLF_OFS_LFTIME, 32'h7, ADLF_RESP_OKAY);
		$display("test loop fault done");
		acc(1, ADLF_OFS_LATCH, 32'h1, ADLF_RESP_OKAY);
		acc(1, ADLF_OFS_LFTIME, 32'h3, ADLF_RESP_OKAY);
		wt(0, 1'b1);
		win("latch set", 0, 40);
		dev <= 16'd50;
		stay(0, 1'b1);
		acc(1, ADLF_OFS_LATCH, 32'h0, ADLF_RESP_OKAY);
		wt(0, 1'b0);
		win("latch free", 0, 6);
		acc(1, ADLF_OFS_CTRL, 32'hf1, ADLF_RESP_OKAY);
		acc(0, ADLF_OFS_LFLVL, 32'h3e8, ADLF_RESP_OKAY);
		acc(0, ADLF_OFS_LFBND, 32'h14, ADLF_RESP_OKAY);
		$display("test latch and analog done");
		summarize();
	end
endmodule : tb_alarm_delay_loop_fault
